// file: hw/sleep_gate_consts.vh
// constants for the sleep-mode clock gate bank: offsets, fields, resets
`ifndef SLEEP_GATE_CONSTS_VH
`define SLEEP_GATE_CONSTS_VH

// ----------------------------------------------------------------------
// address map (byte offsets inside the system control block)
// ----------------------------------------------------------------------
`define SYSCTL_BASE       32'h400FE000
`define ADDR_W            12
`define OFS_RUN_GATE      12'h104
`define OFS_SLEEP_GATE    12'h114
`define OFS_DEEP_GATE     12'h124
`define OFS_RUN_CFG       12'h0F0
`define OFS_IRQ_STATUS    12'h130
`define OFS_IRQ_MASK      12'h134
`define OFS_GATE_STATE    12'h138

// ----------------------------------------------------------------------
// gating register fields (same layout in run, sleep and deep-sleep)
// ----------------------------------------------------------------------
`define BIT_GP_COUNTER2   18
`define BIT_GP_COUNTER1   17
`define BIT_GP_COUNTER0   16
`define BIT_TWO_WIRE0     12
`define BIT_SYNC_SERIAL0  4
`define BIT_ASYNC_SERIAL1 1
`define BIT_ASYNC_SERIAL0 0
`define GATE_MASK         32'h00071013
`define GATE_RESET        32'h00000000
`define NUM_PERIPH        7

// ----------------------------------------------------------------------
// run clock configuration, interrupt and state register fields
// ----------------------------------------------------------------------
`define CFG_AUTO_BIT      0
`define CFG_RESET         32'h00000000
`define IRQ_W             4
`define IRQ_FAULT         0
`define IRQ_SLEEP         1
`define IRQ_DEEP          2
`define IRQ_WAKE          3
`define IRQ_RESET         4'h0
`define STATE_PWR_LSB     8
`define STATE_AUTO_BIT    12

// ----------------------------------------------------------------------
// bus answer codes and timing
// ----------------------------------------------------------------------
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`define BUS_WAIT_CYCLES   1

`endif

// file: hw/periph_gate_cell.v
// one peripheral's clock gate: picks the active bit, holds enable, flags faults
`timescale 1ns/10ps
`default_nettype none

module periph_gate_cell (
  // clock and reset
  input  wire mclk,
  input  wire rst_n,
  // gate bits from the three gating registers
  input  wire runBit,
  input  wire sleepBit,
  input  wire deepBit,
  // power state and selection
  input  wire autoSel,
  input  wire inSleep,
  input  wire inDeep,
  // peripheral access check
  input  wire accessReq,
  output wire clkEn,
  output wire accessFault
);

  reg  clkEn_ff;   // registered so the enable never glitches mid-cycle
  reg  nxt_clkEn;  // selected gate bit

  // ----------------------------------------------------------------------
  // gate selection by power state
  // ----------------------------------------------------------------------
  // without auto select the run bit rules in every state
  always @* begin
    nxt_clkEn = runBit;
    if (autoSel && inDeep) begin
      nxt_clkEn = deepBit;
    end else if (autoSel && inSleep) begin
      nxt_clkEn = sleepBit;
    end else begin
      nxt_clkEn = runBit;
    end
  end

  // enable flop, cleared so the unit starts unclocked
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clkEn_ff <= 1'b0;
    end else begin
      clkEn_ff <= nxt_clkEn;
    end
  end

  assign clkEn       = clkEn_ff;
  // a touch of an unclocked unit is answered as a fault
  assign accessFault = accessReq & ~clkEn_ff;

endmodule
`default_nettype wire

// file: hw/sleep_mode_clock_gate_bank.v
// sleep-mode clock gate bank with run/deep companions and avalon slave
//
// Summary of operation
// - gate bit one clocks unit, zero disables
// - access to gated-off unit gets bus fault
// - reset clears all sleep gate bits
// - with auto select set, power state picks run, sleep or deep gates
// - sleep gates apply only with auto select set
// - bits 18,17,16 gate counters two, one, zero
// - bit 12 gates two-wire serial unit zero
// - bit 4 gates synchronous serial unit zero
// - bits 1,0 gate async serial one, zero
// - reserved bits read zero, writes ignored
// - sleep gate register sits at offset 0x114
`timescale 1ns/10ps
`default_nettype none
`include "sleep_gate_consts.vh"

module sleep_mode_clock_gate_bank (
  // clock and reset
  input  wire                      mclk,
  input  wire                      rst_n,
  // avalon-mm slave
  input  wire [`ADDR_W-1:0]        address,
  input  wire                      read,
  input  wire                      write,
  input  wire [31:0]               writedata,
  input  wire [3:0]                byteenable,
  output wire                      waitrequest,
  output wire [31:0]               readdata,
  output wire [1:0]                response,
  // power state requests from the core, same clock
  input  wire                      sleepReq,
  input  wire                      deepSleepReq,
  // peripheral side: access strobes in, enables and fault out
  input  wire [`NUM_PERIPH-1:0]    periphReq,
  output wire [`NUM_PERIPH-1:0]    periphClkEn,
  output wire                      periphFault,
  // interrupt
  output wire                      irq
);

  // ----------------------------------------------------------------------
  // power state machine encoding (one-hot)
  // ----------------------------------------------------------------------
  localparam [2:0] PWR_RUN   = 3'h1; // normal running
  localparam [2:0] PWR_SLEEP = 3'h2; // sleep
  localparam [2:0] PWR_DEEP  = 3'h4; // deep sleep

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  reg  [31:0]             runGate_ff;    // run-mode gates
  reg  [31:0]             sleepGate_ff;  // sleep-mode gates
  reg  [31:0]             deepGate_ff;   // deep-sleep gates
  reg  [31:0]             runCfg_ff;     // run clock config, auto select
  reg  [`IRQ_W-1:0]       irqStatus_ff;  // sticky events
  reg  [`IRQ_W-1:0]       irqMask_ff;    // event enables
  reg  [2:0]              pwrState_ff;   // one-hot power state
  reg  [2:0]              nxt_pwrState;  // next power state
  reg                     ack_ff;        // second cycle of a bus request
  reg  [31:0]             readdata_ff;   // captured read word
  reg  [1:0]              response_ff;   // captured answer code
  reg  [31:0]             nxt_readdata;  // read mux result
  reg                     nxt_hit;       // address is mapped
  reg  [`IRQ_W-1:0]       nxt_irqStatus; // status after set and clear

  // ----------------------------------------------------------------------
  // wires
  // ----------------------------------------------------------------------
  wire                    busReq;        // read or write pending
  wire                    busTake;       // request completes this edge
  wire                    wrTake;        // write completes this edge
  wire [31:0]             beMask;        // byte lanes as bit mask
  wire [31:0]             wrBits;        // masked write data
  wire                    autoSel;       // auto clock gating selected
  wire [`NUM_PERIPH-1:0]  runVec;        // compressed run gates
  wire [`NUM_PERIPH-1:0]  sleepVec;      // compressed sleep gates
  wire [`NUM_PERIPH-1:0]  deepVec;       // compressed deep gates
  wire [`NUM_PERIPH-1:0]  faultVec;      // per-unit fault flags
  wire [`IRQ_W-1:0]       irqEvent;      // this cycle's events
  wire [31:0]             gateState;     // live state readback

  // ----------------------------------------------------------------------
  // gate field extraction
  // ----------------------------------------------------------------------
  // index 0..6: async0, async1, sync0, two-wire0, counter0, 1, 2
  function [`NUM_PERIPH-1:0] gateVec;
    input [31:0] r;
    begin
      gateVec = {r[`BIT_GP_COUNTER2],
                 r[`BIT_GP_COUNTER1],
                 r[`BIT_GP_COUNTER0],
                 r[`BIT_TWO_WIRE0],
                 r[`BIT_SYNC_SERIAL0],
                 r[`BIT_ASYNC_SERIAL1],
                 r[`BIT_ASYNC_SERIAL0]};
    end
  endfunction

  assign runVec   = gateVec(runGate_ff);
  assign sleepVec = gateVec(sleepGate_ff);
  assign deepVec  = gateVec(deepGate_ff);
  assign autoSel  = runCfg_ff[`CFG_AUTO_BIT];

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  // one wait state: the first cycle decodes, the second answers.
  // costs a cycle per access but keeps the read mux off the output path.
  assign busReq      = read | write;
  assign busTake     = busReq & ack_ff;
  assign wrTake      = write & ack_ff;
  assign waitrequest = busReq & ~ack_ff;

  // ack toggles high for exactly the answering cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else if (busTake) begin
      ack_ff <= 1'b0; // request released after this edge
    end else begin
      ack_ff <= busReq;
    end
  end

  // byte lanes expand to a bit mask for partial writes
  assign beMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                   {8{byteenable[1]}}, {8{byteenable[0]}}};
  // reserved bits of the gate registers never take a write
  assign wrBits = writedata & beMask;

  // ----------------------------------------------------------------------
  // address decode and read mux
  // ----------------------------------------------------------------------
  // gate registers hold only implemented bits, so reserved bits read zero
  always @* begin
    nxt_hit      = 1'b1;
    nxt_readdata = 32'h00000000;
    case (address)
      `OFS_RUN_GATE: begin
        nxt_readdata = runGate_ff;
      end
      `OFS_SLEEP_GATE: begin
        nxt_readdata = sleepGate_ff & `GATE_MASK;
      end
      `OFS_DEEP_GATE: begin
        nxt_readdata = deepGate_ff;
      end
      `OFS_RUN_CFG: begin
        nxt_readdata = runCfg_ff;
      end
      `OFS_IRQ_STATUS: begin
        nxt_readdata = {{(32-`IRQ_W){1'b0}}, irqStatus_ff};
      end
      `OFS_IRQ_MASK: begin
        nxt_readdata = {{(32-`IRQ_W){1'b0}}, irqMask_ff};
      end
      `OFS_GATE_STATE: begin
        nxt_readdata = gateState;
      end
      default: begin
        // unmapped offset answers with a slave error and zero data
        nxt_hit      = 1'b0;
        nxt_readdata = 32'h00000000;
      end
    endcase
  end

  // read data and answer code are captured in the decode cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readdata_ff <= 32'h00000000;
      response_ff <= `RESP_OKAY;
    end else if (busReq && !ack_ff) begin
      readdata_ff <= read ? nxt_readdata : 32'h00000000;
      response_ff <= nxt_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  assign readdata = readdata_ff;
  assign response = response_ff;

  // ----------------------------------------------------------------------
  // gating registers
  // ----------------------------------------------------------------------
  // all three start cleared, so every unit begins unclocked;
  // software must enable what it needs before touching it
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      runGate_ff   <= `GATE_RESET;
      sleepGate_ff <= `GATE_RESET;
      deepGate_ff  <= `GATE_RESET;
    end else if (wrTake) begin
      if (address == `OFS_RUN_GATE) begin
        runGate_ff <= ((runGate_ff & ~beMask) | wrBits) & `GATE_MASK;
      end
      if (address == `OFS_SLEEP_GATE) begin
        // reserved lanes drop out, so read-modify-write is harmless
        sleepGate_ff <= ((sleepGate_ff & ~beMask) | wrBits) & `GATE_MASK;
      end
      if (address == `OFS_DEEP_GATE) begin
        deepGate_ff <= ((deepGate_ff & ~beMask) | wrBits) & `GATE_MASK;
      end
    end
  end

  // run clock config: only the auto select bit is implemented here
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      runCfg_ff <= `CFG_RESET;
    end else if (wrTake && address == `OFS_RUN_CFG && byteenable[0]) begin
      runCfg_ff <= {31'h00000000, writedata[`CFG_AUTO_BIT]};
    end
  end

  // ----------------------------------------------------------------------
  // power state machine
  // ----------------------------------------------------------------------
  // deep sleep wins when both requests are high; leaving deep falls to sleep while sleepReq holds, else run
  always @* begin
    nxt_pwrState = pwrState_ff;
    case (pwrState_ff)
      PWR_RUN: begin
        if (deepSleepReq) begin
          nxt_pwrState = PWR_DEEP;
        end else if (sleepReq) begin
          nxt_pwrState = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (deepSleepReq) begin
          nxt_pwrState = PWR_DEEP;
        end else if (!sleepReq) begin
          nxt_pwrState = PWR_RUN;
        end
      end
      PWR_DEEP: begin
        if (!deepSleepReq) begin
          nxt_pwrState = sleepReq ? PWR_SLEEP : PWR_RUN;
        end
      end
      default: begin
        // illegal code recovers to run
        nxt_pwrState = PWR_RUN;
      end
    endcase
  end

  // state flop
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pwrState_ff <= PWR_RUN;
    end else begin
      pwrState_ff <= nxt_pwrState;
    end
  end

  // ----------------------------------------------------------------------
  // per-peripheral gates
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_PERIPH; gi = gi + 1) begin : gateCell
      periph_gate_cell uCell (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .runBit      (runVec[gi]),
        .sleepBit    (sleepVec[gi]),
        .deepBit     (deepVec[gi]),
        .autoSel     (autoSel),
        .inSleep     (pwrState_ff[1]),
        .inDeep      (pwrState_ff[2]),
        .accessReq   (periphReq[gi]),
        .clkEn       (periphClkEn[gi]),
        .accessFault (faultVec[gi])
      );
    end
  endgenerate

  // any strobe at a gated unit is answered as a bus fault
  assign periphFault = |faultVec;

  // live readback: enables, power state, auto select
  assign gateState = {19'h00000, autoSel, 1'b0, pwrState_ff,
                      1'b0, periphClkEn};

  // ----------------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------------
  // events: fault, entry to sleep, entry to deep sleep, return to run
  assign irqEvent[`IRQ_FAULT] = periphFault;
  assign irqEvent[`IRQ_SLEEP] = (nxt_pwrState == PWR_SLEEP) &&
                                (pwrState_ff != PWR_SLEEP);
  assign irqEvent[`IRQ_DEEP]  = (nxt_pwrState == PWR_DEEP) &&
                                (pwrState_ff != PWR_DEEP);
  assign irqEvent[`IRQ_WAKE]  = (nxt_pwrState == PWR_RUN) &&
                                (pwrState_ff != PWR_RUN);

  // write-one-to-clear; a new event in the same cycle wins the clear
  always @* begin
    nxt_irqStatus = irqStatus_ff;
    if (wrTake && address == `OFS_IRQ_STATUS && byteenable[0]) begin
      nxt_irqStatus = irqStatus_ff & ~writedata[`IRQ_W-1:0];
    end
    nxt_irqStatus = nxt_irqStatus | irqEvent;
  end

  // status and mask flops
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStatus_ff <= `IRQ_RESET;
      irqMask_ff   <= `IRQ_RESET;
    end else begin
      irqStatus_ff <= nxt_irqStatus;
      if (wrTake && address == `OFS_IRQ_MASK && byteenable[0]) begin
        irqMask_ff <= writedata[`IRQ_W-1:0];
      end
    end
  end

  // level interrupt while any unmasked status bit stands
  assign irq = |(irqStatus_ff & irqMask_ff);

endmodule
`default_nettype wire

// file: tb/sleep_gate_checker_asserts.sv
// port-level assertion checker for the sleep-mode clock gate bank
`timescale 1ns/10ps
`default_nettype none
`include "sleep_gate_consts.vh"
module sleep_gate_checker (
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_n,
  // register bus
  input wire logic [`ADDR_W-1:0]     address,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [31:0]            writedata,
  input wire logic [3:0]             byteenable,
  input wire logic                   waitrequest,
  input wire logic [31:0]            readdata,
  input wire logic [1:0]             response,
  // power requests and peripheral side
  input wire logic                   sleepReq,
  input wire logic                   deepSleepReq,
  input wire logic [`NUM_PERIPH-1:0] periphReq,
  input wire logic [`NUM_PERIPH-1:0] periphClkEn,
  input wire logic                   periphFault,
  input wire logic                   irq
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic [31:0] shadow_ff;   // expected sleep gate contents
  logic        shadowOk_ff; // cleared after a partial-lane write
  logic        sleepQ_ff;   // last sampled sleep request
  logic        deepQ_ff;    // last sampled deep request
  logic [1:0]  cause_ff;    // enable change allowed, two-deep for latency
  // cause pipeline: enables may only move after a write or a power change
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_ff   <= `GATE_RESET;
      shadowOk_ff <= 1'b1;
      sleepQ_ff   <= 1'b0;
      deepQ_ff    <= 1'b0;
      cause_ff    <= 2'h0;
    end else begin
      sleepQ_ff <= sleepReq;
      deepQ_ff  <= deepSleepReq;
      cause_ff  <= {cause_ff[0], (write & ~waitrequest) | (sleepReq ^ sleepQ_ff)
                    | (deepSleepReq ^ deepQ_ff)};
      // only full-word writes are tracked, anything else gives up
      if (write && !waitrequest && address == `OFS_SLEEP_GATE) begin
        if (byteenable == 4'hF) begin
          shadow_ff <= writedata & `GATE_MASK;
        end else begin
          shadowOk_ff <= 1'b0;
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_fault_answer: assert property (periphFault == |(periphReq & ~periphClkEn))
    else $error("fault output does not match gated access");
  a_reset_clears: assert property ($rose(rst_n) |-> periphClkEn == 7'h00 && !irq)
    else $error("enables not clear after reset");
  a_first_wait: assert property ($rose(read | write) |-> waitrequest)
    else $error("request answered without wait state");
  a_one_wait: assert property ((read | write) && waitrequest |=> !waitrequest)
    else $error("request held longer than one wait state");
  a_enable_cause: assert property ($changed(periphClkEn) |-> |cause_ff)
    else $error("enables moved without write or power change");
  a_reserved_zero: assert property (read && !waitrequest && address == `OFS_SLEEP_GATE
    |-> (readdata & ~`GATE_MASK) == 32'h00000000 && response == `RESP_OKAY)
    else $error("reserved sleep gate bits read nonzero");
  a_gate_readback: assert property (read && !waitrequest && address == `OFS_SLEEP_GATE
    && shadowOk_ff |-> readdata == shadow_ff)
    else $error("sleep gate readback differs from written value");
  a_unmapped_err: assert property (read && !waitrequest && address == 12'h200
    |-> response == `RESP_SLVERR && readdata == 32'h00000000)
    else $error("unmapped read not refused");
endmodule
bind sleep_mode_clock_gate_bank sleep_gate_checker sleep_gate_checker_inst (.*);
`default_nettype wire

// file: tb/sleep_mode_clock_gate_bank_tb.sv
// self-checking testbench for the sleep-mode clock gate bank
`timescale 1ns/10ps
`default_nettype none
`include "sleep_gate_consts.vh"
module sleep_mode_clock_gate_bank_tb;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic                   mclk = 1'b0;
  logic                   rst_n = 1'b0;
  logic [`ADDR_W-1:0]     address = 12'h000;
  logic                   read = 1'b0;
  logic                   write = 1'b0;
  logic [31:0]            writedata = 32'h00000000;
  logic [3:0]             byteenable = 4'hF; // full words unless a scenario narrows lanes
  logic                   waitrequest;
  logic [31:0]            readdata;
  logic [1:0]             response;
  logic                   sleepReq = 1'b0;
  logic                   deepSleepReq = 1'b0;
  logic [`NUM_PERIPH-1:0] periphReq = 7'h00;
  logic [`NUM_PERIPH-1:0] periphClkEn;
  logic                   periphFault;
  logic                   irq;
  logic [31:0]            rdq;   // data taken by the last bus cycle
  logic [1:0]             rsp;   // response taken by the last bus cycle
  int                     fails = 0;
  int                     checks = 0;
  int                     bits[7] = '{0, 1, 4, 12, 16, 17, 18}; // gate bit per unit index
  always #10 mclk = ~mclk;
  sleep_mode_clock_gate_bank sleep_mode_clock_gate_bank_inst (
    .mclk(mclk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .waitrequest(waitrequest),
    .readdata(readdata), .response(response), .sleepReq(sleepReq),
    .deepSleepReq(deepSleepReq), .periphReq(periphReq), .periphClkEn(periphClkEn),
    .periphFault(periphFault), .irq(irq));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon transfer; held until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge mclk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    @(posedge mclk iff waitrequest === 1'b0);
    rdq = readdata;
    rsp = response;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // power request change, then the enables after their fixed latency
  task automatic pwrChk(input logic s, input logic d, input logic [31:0] gate);
    @(posedge mclk);
    sleepReq <= s;
    deepSleepReq <= d;
    repeat (4) @(posedge mclk);
    chk("enables in power state", {25'h0, periphClkEn}, toEn(gate));
  endtask
  function automatic logic [31:0] toEn(input logic [31:0] g);
    toEn = {25'h0, g[18], g[17], g[16], g[12], g[4], g[1], g[0]};
  endfunction
  task automatic report_and_stop;
    if (fails == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic testReset;
    bus(1'b0, `OFS_SLEEP_GATE, 32'h0);
    chk("sleep gate reset", rdq, `GATE_RESET);
    chk("enables at reset", {25'h0, periphClkEn}, 32'h0);
  endtask
  // each gate bit alone, then all ones to expose reserved bits
  task automatic testFields;
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, `OFS_SLEEP_GATE, 32'h1 << bits[i]);
      bus(1'b0, `OFS_SLEEP_GATE, 32'h0);
      chk("sleep gate bit", rdq, 32'h1 << bits[i]);
    end
    bus(1'b1, `OFS_SLEEP_GATE, 32'hFFFFFFFF);
    bus(1'b0, `OFS_SLEEP_GATE, 32'h0);
    chk("reserved bits", rdq, 32'h00071013);
    // software style update: clear one gate, write back what was read
    bus(1'b1, `OFS_SLEEP_GATE, rdq & ~32'h00000001);
    bus(1'b0, `OFS_SLEEP_GATE, 32'h0);
    chk("read-modify-write", rdq, 32'h00071012);
    // lane 2 only: the counter gates clear, the rest must survive
    byteenable <= 4'h4;
    bus(1'b1, `OFS_SLEEP_GATE, 32'h0);
    byteenable <= 4'hF;
    bus(1'b0, `OFS_SLEEP_GATE, 32'h0);
    chk("lane write", rdq, 32'h00001012);
  endtask
  // run gates drive each enable; gated units answer with a fault
  task automatic testRunGate;
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, `OFS_RUN_GATE, 32'h1 << bits[i]);
      repeat (3) @(posedge mclk);
      chk("unit enable", {25'h0, periphClkEn}, 32'h1 << i);
      periphReq <= 7'h1 << i;
      @(negedge mclk);
      chk("clocked access", {31'h0, periphFault}, 32'h0);
      @(posedge mclk);
      periphReq <= ~(7'h1 << i);
      @(negedge mclk);
      chk("gated access", {31'h0, periphFault}, 32'h1);
      @(posedge mclk);
      periphReq <= 7'h00;
    end
  endtask
  // state selects run, sleep or deep gates only when auto select is on
  task automatic testPower;
    bus(1'b1, `OFS_RUN_GATE, 32'h00010001);
    bus(1'b1, `OFS_SLEEP_GATE, 32'h00020010);
    bus(1'b1, `OFS_DEEP_GATE, 32'h00041002);
    bus(1'b0, `OFS_DEEP_GATE, 32'h0);
    chk("deep gate readback", rdq, 32'h00041002);
    bus(1'b1, `OFS_RUN_CFG, 32'h0);
    pwrChk(1'b1, 1'b0, 32'h00010001);
    pwrChk(1'b0, 1'b1, 32'h00010001);
    pwrChk(1'b0, 1'b0, 32'h00010001);
    bus(1'b1, `OFS_RUN_CFG, 32'h1);
    pwrChk(1'b1, 1'b0, 32'h00020010);
    pwrChk(1'b1, 1'b1, 32'h00041002);
    pwrChk(1'b0, 1'b0, 32'h00010001);
  endtask
  // fault event is sticky, masked, unmasked and cleared by writing one
  task automatic testIrq;
    bus(1'b1, `OFS_RUN_GATE, 32'h0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h0000000F);
    @(posedge mclk);
    periphReq <= 7'h40;
    repeat (2) @(posedge mclk);
    periphReq <= 7'h00;
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("fault status", rdq, 32'h1);
    chk("masked irq", {31'h0, irq}, 32'h0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    @(negedge mclk);
    chk("unmasked irq", {31'h0, irq}, 32'h1);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h1);
    @(negedge mclk);
    chk("cleared irq", {31'h0, irq}, 32'h0);
    bus(1'b0, 12'h200, 32'h0);
    chk("unmapped response", {30'h0, rsp}, {30'h0, `RESP_SLVERR});
    // power events land in status bits 1..3; status is clear here
    pwrChk(1'b1, 1'b0, 32'h00020010);
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("sleep entry event", rdq, 32'h2);
    pwrChk(1'b0, 1'b1, 32'h00041002);
    bus(1'b0, `OFS_GATE_STATE, 32'h0);
    chk("live gate state", rdq, 32'h0000144A);
    pwrChk(1'b0, 1'b0, 32'h0);
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("deep and wake events", rdq, 32'hE);
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    testReset();
    testFields();
    // second reset with the sleep gates loaded: all must clear again
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    testReset();
    testRunGate();
    testPower();
    testIrq();
    report_and_stop();
  end
  // the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
